// ==== core/iom_mux.sv ====
module iom_mux (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [77:0] i_pin_mode,
  input  wire logic [25:0] i_pin_out_data,
  input  wire logic [25:0] i_pin_oe,
  output logic      [25:0] o_pin_in_level,
  input  wire logic [25:0] i_irq_sense_select,
  input  wire logic [25:0] i_irq_both_edge_select,
  input  wire logic [25:0] i_irq_polarity_select,
  input  wire logic [25:0] i_pin_irq_enable_mask,
  input  wire logic [25:0] i_pin_irq_clear,
  output logic      [25:0] o_pin_irq_pending,
  output logic             o_irq,
  input  wire logic [25:0] i_pad_in,
  output logic      [25:0] o_pad_out,
  output logic      [25:0] o_pad_oe,
  input  wire logic        i_uart_txd,
  input  wire logic        i_uart_rts,
  output logic             o_uart_rxd,
  output logic             o_uart_cts,
  input  wire logic        i_spi_clk_out,
  input  wire logic        i_spi_clk_oe,
  output logic             o_spi_clk_in,
  input  wire logic        i_spi_out,
  output logic             o_spi_in,
  input  wire logic        i_spi_select_one_out,
  input  wire logic        i_spi_select_one_oe,
  output logic             o_spi_select_one_in,
  input  wire logic        i_spi_select_two,
  input  wire logic        i_spi_select_three,
  input  wire logic        i_first_twowire_clock_oe,
  input  wire logic        i_first_twowire_data_oe,
  output logic             o_first_twowire_clock,
  output logic             o_first_twowire_data,
  input  wire logic        i_second_twowire_clock_oe,
  input  wire logic        i_second_twowire_data_oe,
  output logic             o_second_twowire_clock,
  output logic             o_second_twowire_data,
  input  wire logic        i_pulse_source_a,
  input  wire logic        i_pulse_source_b,
  input  wire logic        i_mic_stream_clock_out,
  output logic             o_mic_stream_data_in,
  input  wire logic        i_core_clock_out,
  input  wire logic        i_fast_crystal_clock_out,
  input  wire logic        i_slow_clock_out,
  output logic             o_swd_clock,
  input  wire logic        i_swd_data_out,
  input  wire logic        i_swd_data_oe,
  output logic             o_swd_data_in
);
  localparam int N = iom_pkg::NUM_PINS;

  logic [N-1:0] sync_a;
  logic [N-1:0] sync_b;
  logic [N-1:0] prev;
  logic [N-1:0] pending;
  logic [N-1:0] hit;
  logic [N-1:0] io_mode;
  logic [N-1:0] next_out;
  logic [N-1:0] next_oe;
  logic [N-1:0] next_pending;
  logic [2:0]   warm;

  function automatic logic [2:0] mode_of(input logic [77:0] m, input int p);
    mode_of = m[3*p +: 3];
  endfunction

  function automatic logic is_mode(input logic [77:0] m, input int p, input logic [2:0] c);
    is_mode = (mode_of(m, p) == c);
  endfunction

  // two-stage pin synchroniser and previous sample
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_a <= iom_pkg::RST_DATA;
      sync_b <= iom_pkg::RST_DATA;
      prev   <= iom_pkg::RST_DATA;
    end else begin
      sync_a <= i_pad_in;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  assign o_pin_in_level = sync_b;

  // triggers wait until prev holds a real pad sample, so pulled-up pins show no false edge after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      warm <= 3'h0;
    end else begin
      warm <= {warm[1:0], 1'b1};
    end
  end

  // trigger detection per pin
  generate
    for (genvar p = 0; p < N; p++) begin : g_trig
      logic rise;
      logic fall;
      logic edge_hit;
      logic lvl_hit;
      assign io_mode[p] = is_mode(i_pin_mode, p, iom_pkg::MODE_IO);
      assign rise       = sync_b[p] & ~prev[p];
      assign fall       = ~sync_b[p] & prev[p];
      assign edge_hit   = i_irq_both_edge_select[p] ? (rise | fall)
                        : (i_irq_polarity_select[p] ? rise : fall);
      assign lvl_hit    = (sync_b[p] == i_irq_polarity_select[p]);
      assign hit[p]     = warm[2] & io_mode[p] & (i_irq_sense_select[p] ? lvl_hit : edge_hit);
    end
  endgenerate

  // sticky pending flags, a new event wins over a clear
  always_comb begin
    next_pending = (pending & ~i_pin_irq_clear) | hit;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pending <= iom_pkg::RST_CFG;
    end else begin
      pending <= next_pending;
    end
  end

  assign o_pin_irq_pending = pending;

  // single merged request line
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(next_pending & i_pin_irq_enable_mask);
    end
  end

  // pad drive selection per pin and mode
  always_comb begin
    next_out = '0;
    next_oe  = '0;
    for (int p = 0; p < N; p++) begin
      if (is_mode(i_pin_mode, p, iom_pkg::MODE_IO)) begin
        next_out[p] = i_pin_out_data[p];
        next_oe[p]  = i_pin_oe[p] & ~iom_pkg::INPUT_ONLY[p];
      end
    end
    // alternate set one
    if (is_mode(i_pin_mode, 1, iom_pkg::MODE_ALT1))  begin next_out[1] = i_uart_rts; next_oe[1] = 1'b1; end
    if (is_mode(i_pin_mode, 6, iom_pkg::MODE_ALT1))  begin next_out[6] = i_uart_rts; next_oe[6] = 1'b1; end
    if (is_mode(i_pin_mode, 25, iom_pkg::MODE_ALT1)) begin next_out[25] = i_uart_rts; next_oe[25] = 1'b1; end
    if (is_mode(i_pin_mode, 2, iom_pkg::MODE_ALT1))  begin next_out[2] = i_pulse_source_a; next_oe[2] = 1'b1; end
    if (is_mode(i_pin_mode, 16, iom_pkg::MODE_ALT1)) begin next_out[16] = i_pulse_source_a; next_oe[16] = 1'b1; end
    if (is_mode(i_pin_mode, 22, iom_pkg::MODE_ALT1)) begin next_out[22] = i_pulse_source_a; next_oe[22] = 1'b1; end
    if (is_mode(i_pin_mode, 3, iom_pkg::MODE_ALT1))  begin next_out[3] = i_pulse_source_b; next_oe[3] = 1'b1; end
    if (is_mode(i_pin_mode, 17, iom_pkg::MODE_ALT1)) begin next_out[17] = i_pulse_source_b; next_oe[17] = 1'b1; end
    if (is_mode(i_pin_mode, 21, iom_pkg::MODE_ALT1)) begin next_out[21] = i_pulse_source_b; next_oe[21] = 1'b1; end
    if (is_mode(i_pin_mode, 5, iom_pkg::MODE_ALT1))  begin next_out[5] = i_uart_txd; next_oe[5] = 1'b1; end
    if (is_mode(i_pin_mode, 8, iom_pkg::MODE_ALT1))  begin next_out[8] = i_uart_txd; next_oe[8] = 1'b1; end
    if (is_mode(i_pin_mode, 23, iom_pkg::MODE_ALT1)) begin next_out[23] = i_uart_txd; next_oe[23] = 1'b1; end
    if (is_mode(i_pin_mode, 10, iom_pkg::MODE_ALT1)) begin next_out[10] = i_swd_data_out; next_oe[10] = i_swd_data_oe; end
    if (is_mode(i_pin_mode, 14, iom_pkg::MODE_ALT1)) begin next_out[14] = 1'b0; next_oe[14] = i_first_twowire_clock_oe; end
    if (is_mode(i_pin_mode, 15, iom_pkg::MODE_ALT1)) begin next_out[15] = 1'b0; next_oe[15] = i_first_twowire_data_oe; end
    if (is_mode(i_pin_mode, 18, iom_pkg::MODE_ALT1)) begin next_out[18] = i_spi_select_two; next_oe[18] = 1'b1; end
    if (is_mode(i_pin_mode, 19, iom_pkg::MODE_ALT1)) begin next_out[19] = i_spi_select_three; next_oe[19] = 1'b1; end
    // alternate set zero
    for (int p = 0; p < N; p++) begin
      if (is_mode(i_pin_mode, p, iom_pkg::MODE_ALT0)) begin
        unique case (p)
          0, 8, 14, 25:  begin next_out[p] = i_spi_clk_out; next_oe[p] = i_spi_clk_oe; end
          2, 10, 17, 23: begin next_out[p] = i_spi_out; next_oe[p] = 1'b1; end
          1, 11, 15, 21: begin next_out[p] = i_spi_select_one_out; next_oe[p] = i_spi_select_one_oe; end
          20:            begin next_out[p] = i_spi_select_two; next_oe[p] = 1'b1; end
          22:            begin next_out[p] = i_spi_select_three; next_oe[p] = 1'b1; end
          4, 6:          begin next_out[p] = 1'b0; next_oe[p] = i_second_twowire_clock_oe; end
          5, 7:          begin next_out[p] = 1'b0; next_oe[p] = i_second_twowire_data_oe; end
          12:            begin next_out[p] = 1'b0; next_oe[p] = i_first_twowire_clock_oe; end
          13:            begin next_out[p] = 1'b0; next_oe[p] = i_first_twowire_data_oe; end
          18:            begin next_out[p] = i_uart_rts; next_oe[p] = 1'b1; end
          default:       begin next_out[p] = 1'b0; next_oe[p] = 1'b0; end
        endcase
      end
    end
    // alternate set two
    if (is_mode(i_pin_mode, 4, iom_pkg::MODE_ALT2)) begin next_out[4] = i_pulse_source_a; next_oe[4] = 1'b1; end
    if (is_mode(i_pin_mode, 5, iom_pkg::MODE_ALT2)) begin next_out[5] = i_pulse_source_b; next_oe[5] = 1'b1; end
    for (int p = 0; p < N; p++) begin
      if (is_mode(i_pin_mode, p, iom_pkg::MODE_ALT2) && (p == 2 || p == 7 || p == 23 || p == 25)) begin
        next_out[p] = i_mic_stream_clock_out;
        next_oe[p]  = 1'b1;
      end
    end
    if (is_mode(i_pin_mode, 0, iom_pkg::MODE_ALT2))  begin next_out[0] = i_core_clock_out; next_oe[0] = 1'b1; end
    if (is_mode(i_pin_mode, 9, iom_pkg::MODE_ALT2))  begin next_out[9] = i_fast_crystal_clock_out; next_oe[9] = 1'b1; end
    if (is_mode(i_pin_mode, 10, iom_pkg::MODE_ALT2)) begin next_out[10] = i_slow_clock_out; next_oe[10] = 1'b1; end
    if (is_mode(i_pin_mode, 11, iom_pkg::MODE_ALT2)) begin next_out[11] = i_slow_clock_out; next_oe[11] = 1'b1; end
  end

  // registered pad drive, all pins released at reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad_out <= iom_pkg::RST_DATA;
      o_pad_oe  <= iom_pkg::RST_OE;
    end else begin
      o_pad_out <= next_out;
      o_pad_oe  <= next_oe;
    end
  end

  // peripheral inputs from synchronised pins; first selected pin wins, idle high except spi clock, spi in, mic data and swd clock, which idle low
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_uart_rxd             <= 1'b1;
      o_uart_cts             <= 1'b1;
      o_spi_clk_in           <= 1'b0;
      o_spi_in               <= 1'b0;
      o_spi_select_one_in    <= 1'b1;
      o_first_twowire_clock  <= 1'b1;
      o_first_twowire_data   <= 1'b1;
      o_second_twowire_clock <= 1'b1;
      o_second_twowire_data  <= 1'b1;
      o_mic_stream_data_in   <= 1'b0;
      o_swd_clock            <= 1'b0;
      o_swd_data_in          <= 1'b1;
    end else begin
      o_uart_rxd <= is_mode(i_pin_mode, 4, iom_pkg::MODE_ALT1) ? sync_b[4] :
                    is_mode(i_pin_mode, 11, iom_pkg::MODE_ALT1) ? sync_b[11] :
                    is_mode(i_pin_mode, 24, iom_pkg::MODE_ALT1) ? sync_b[24] : 1'b1;
      o_uart_cts <= is_mode(i_pin_mode, 0, iom_pkg::MODE_ALT1) ? sync_b[0] :
                    is_mode(i_pin_mode, 7, iom_pkg::MODE_ALT1) ? sync_b[7] :
                    is_mode(i_pin_mode, 13, iom_pkg::MODE_ALT1) ? sync_b[13] :
                    is_mode(i_pin_mode, 20, iom_pkg::MODE_ALT1) ? sync_b[20] :
                    is_mode(i_pin_mode, 19, iom_pkg::MODE_ALT0) ? sync_b[19] : 1'b1;
      o_spi_clk_in <= is_mode(i_pin_mode, 0, iom_pkg::MODE_ALT0) ? sync_b[0] :
                      is_mode(i_pin_mode, 8, iom_pkg::MODE_ALT0) ? sync_b[8] :
                      is_mode(i_pin_mode, 14, iom_pkg::MODE_ALT0) ? sync_b[14] :
                      is_mode(i_pin_mode, 25, iom_pkg::MODE_ALT0) ? sync_b[25] : 1'b0;
      o_spi_in <= is_mode(i_pin_mode, 3, iom_pkg::MODE_ALT0) ? sync_b[3] :
                  is_mode(i_pin_mode, 9, iom_pkg::MODE_ALT0) ? sync_b[9] :
                  is_mode(i_pin_mode, 16, iom_pkg::MODE_ALT0) ? sync_b[16] :
                  is_mode(i_pin_mode, 24, iom_pkg::MODE_ALT0) ? sync_b[24] : 1'b0;
      o_spi_select_one_in <= is_mode(i_pin_mode, 1, iom_pkg::MODE_ALT0) ? sync_b[1] :
                             is_mode(i_pin_mode, 11, iom_pkg::MODE_ALT0) ? sync_b[11] :
                             is_mode(i_pin_mode, 15, iom_pkg::MODE_ALT0) ? sync_b[15] :
                             is_mode(i_pin_mode, 21, iom_pkg::MODE_ALT0) ? sync_b[21] : 1'b1;
      o_first_twowire_clock <= is_mode(i_pin_mode, 12, iom_pkg::MODE_ALT0) ? sync_b[12] :
                               is_mode(i_pin_mode, 14, iom_pkg::MODE_ALT1) ? sync_b[14] : 1'b1;
      o_first_twowire_data <= is_mode(i_pin_mode, 13, iom_pkg::MODE_ALT0) ? sync_b[13] :
                              is_mode(i_pin_mode, 15, iom_pkg::MODE_ALT1) ? sync_b[15] : 1'b1;
      o_second_twowire_clock <= is_mode(i_pin_mode, 4, iom_pkg::MODE_ALT0) ? sync_b[4] :
                                is_mode(i_pin_mode, 6, iom_pkg::MODE_ALT0) ? sync_b[6] : 1'b1;
      o_second_twowire_data <= is_mode(i_pin_mode, 5, iom_pkg::MODE_ALT0) ? sync_b[5] :
                               is_mode(i_pin_mode, 7, iom_pkg::MODE_ALT0) ? sync_b[7] : 1'b1;
      o_mic_stream_data_in <= is_mode(i_pin_mode, 1, iom_pkg::MODE_ALT2) ? sync_b[1] :
                              is_mode(i_pin_mode, 6, iom_pkg::MODE_ALT2) ? sync_b[6] :
                              is_mode(i_pin_mode, 8, iom_pkg::MODE_ALT2) ? sync_b[8] :
                              is_mode(i_pin_mode, 24, iom_pkg::MODE_ALT2) ? sync_b[24] : 1'b0;
      o_swd_clock   <= is_mode(i_pin_mode, 9, iom_pkg::MODE_ALT1) ? sync_b[9] : 1'b0;
      o_swd_data_in <= is_mode(i_pin_mode, 10, iom_pkg::MODE_ALT1) ? sync_b[10] : 1'b1;
    end
  end
endmodule

// ==== core/iom_pkg.sv ====
// Contract
// - 3-bit select: 000 io, 001/100/101 alternates
// - pins 12 and 13 never drive in io
// - every io-mode pin can raise interrupt
// - sense, both-edge and polarity choose trigger
// - mask bit equal to pin enables interrupt
// - writing 1 to clear bit clears pending
// - enabled pending flags merge onto one line
// - pulse sources a and b fixed pins
// - mic stream data in, clock out pins
// - code 101 clock outputs on 0,9,10,11
// - code 001 debug clock 9, data 10
// - uart transmit and receive pins
// - uart rts and cts pins
// - spi clock, out and in pins
// - spi chip select pins
// - io output drives data, read shows pin
// - output enable 0 input, resets input
package iom_pkg;
  localparam int          NUM_PINS   = 26;
  localparam logic [2:0]  MODE_IO    = 3'h0;
  localparam logic [2:0]  MODE_ALT1  = 3'h1;
  localparam logic [2:0]  MODE_ALT0  = 3'h4;
  localparam logic [2:0]  MODE_ALT2  = 3'h5;
  localparam logic [25:0] RST_OE     = 26'h0000000;
  localparam logic [25:0] RST_DATA   = 26'h0000000;
  localparam logic [25:0] RST_CFG    = 26'h0000000;
  localparam logic [25:0] INPUT_ONLY = 26'h0003000;
endpackage

// ==== tb/iom_mux_assertions.sv ====
module iom_mux_assertions (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [77:0] i_pin_mode,
  input wire logic [25:0] i_pin_out_data,
  input wire logic [25:0] i_pin_oe,
  input wire logic [25:0] i_irq_sense_select,
  input wire logic [25:0] i_irq_polarity_select,
  input wire logic [25:0] i_pin_irq_enable_mask,
  input wire logic [25:0] i_pin_irq_clear,
  input wire logic [25:0] i_pad_in,
  input wire logic        i_pulse_source_a,
  input wire logic        i_core_clock_out,
  input wire logic [25:0] o_pin_in_level,
  input wire logic [25:0] o_pin_irq_pending,
  input wire logic        o_irq,
  input wire logic [25:0] o_pad_out,
  input wire logic [25:0] o_pad_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] run_cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // edges since reset release, saturating at three, so the checks gated on it never compare history from inside reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) run_cnt <= 2'h0;
    else if (run_cnt != 2'h3) run_cnt <= run_cnt + 2'h1;
  end
  chk_pin12_no_drive: assert property (o_pad_oe[12] |-> $past(i_pin_mode[38:36]) == iom_pkg::MODE_ALT0)
    else $error("pin 12 driven outside two-wire mode");
  chk_pin13_no_drive: assert property (o_pad_oe[13] |-> $past(i_pin_mode[41:39]) == iom_pkg::MODE_ALT0)
    else $error("pin 13 driven outside two-wire mode");
  chk_io_out_dir: assert property (run_cnt != 2'h0 && $past(i_pin_mode[11:9]) == iom_pkg::MODE_IO |->
    o_pad_oe[3] == $past(i_pin_oe[3]) && (!o_pad_oe[3] || o_pad_out[3] == $past(i_pin_out_data[3])))
    else $error("pin 3 io drive wrong");
  chk_pulse_a_route: assert property (run_cnt != 2'h0 && $past(i_pin_mode[8:6]) == iom_pkg::MODE_ALT1 |->
    o_pad_oe[2] && o_pad_out[2] == $past(i_pulse_source_a)) else $error("pin 2 pulse a route wrong");
  chk_core_clk_route: assert property (run_cnt != 2'h0 && $past(i_pin_mode[2:0]) == iom_pkg::MODE_ALT2 |->
    o_pad_oe[0] && o_pad_out[0] == $past(i_core_clock_out)) else $error("pin 0 core clock route wrong");
  chk_level_sync: assert property (run_cnt[1] |-> o_pin_in_level == $past(i_pad_in, 2))
    else $error("pin level not two edges behind pad");
  chk_rise_sets_pend: assert property (run_cnt == 2'h3 && $rose(o_pin_in_level[3]) && i_pin_mode[11:9] == 3'h0
    && !i_irq_sense_select[3] && i_irq_polarity_select[3] |=> o_pin_irq_pending[3]) else $error("rise missed");
  chk_level_holds: assert property (run_cnt == 2'h3 && i_pin_mode[11:9] == 3'h0 && i_irq_sense_select[3]
    && i_irq_polarity_select[3] == o_pin_in_level[3] |=> o_pin_irq_pending[3]) else $error("level lost");
  chk_pend_needs_io: assert property (run_cnt != 2'h0 && $rose(o_pin_irq_pending[3]) |->
    $past(i_pin_mode[11:9]) == iom_pkg::MODE_IO) else $error("pending set outside io mode");
  chk_pend_clear_only: assert property ($fell(o_pin_irq_pending[3]) |-> $past(i_pin_irq_clear[3]))
    else $error("pending dropped without clear");
  chk_irq_merge: assert property (run_cnt != 2'h0 |->
    o_irq == |(o_pin_irq_pending & $past(i_pin_irq_enable_mask))) else $error("irq line wrong");
endmodule

// ==== tb/iom_pads.sv ====
// pad ring: design drive wins, else external source, else pulls; 12 and 13 float
module iom_pads (
  input  wire logic        i_clk,
  input  wire logic [25:0] i_pad_out,
  input  wire logic [25:0] i_pad_oe,
  input  wire logic [25:0] i_ext_val,
  input  wire logic [25:0] i_ext_en,
  output logic      [25:0] o_pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] float_q = 2'h1;
  // unpulled pins toggle so a released line never looks stable
  always_ff @(posedge i_clk) float_q <= ~float_q;
  assign o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext_en & i_ext_val)
                  | (~i_pad_oe & ~i_ext_en & {12'h000, float_q, 12'he00});
endmodule

// ==== tb/test_iom_mux.sv ====
module test_iom_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk, i_rst_n;
  logic [77:0] i_pin_mode;
  logic [25:0] i_pin_out_data, i_pin_oe, i_irq_sense_select, i_irq_both_edge_select, i_irq_polarity_select;
  logic [25:0] i_pin_irq_enable_mask, i_pin_irq_clear, ext_val, ext_en;
  logic [20:0] per;
  wire  [25:0] i_pad_in, o_pin_in_level, o_pin_irq_pending, o_pad_out, o_pad_oe;
  wire         o_irq, o_uart_rxd, o_uart_cts, o_spi_clk_in, o_spi_in, o_spi_select_one_in, o_swd_clock, o_swd_data_in;
  wire         o_first_twowire_clock, o_first_twowire_data, o_second_twowire_clock, o_second_twowire_data;
  wire         o_mic_stream_data_in, i_uart_txd, i_uart_rts, i_spi_clk_out, i_spi_clk_oe, i_spi_out;
  wire         i_spi_select_one_out, i_spi_select_one_oe, i_spi_select_two, i_spi_select_three, i_swd_data_out;
  wire         i_first_twowire_clock_oe, i_first_twowire_data_oe, i_second_twowire_clock_oe, i_swd_data_oe;
  wire         i_second_twowire_data_oe, i_pulse_source_a, i_pulse_source_b, i_mic_stream_clock_out;
  wire         i_core_clock_out, i_fast_crystal_clock_out, i_slow_clock_out;
  wire  [11:0] pout = {o_second_twowire_data, o_second_twowire_clock, o_first_twowire_data, o_first_twowire_clock,
                       o_swd_data_in, o_spi_select_one_in, o_spi_clk_in, o_swd_clock, o_spi_in,
                       o_mic_stream_data_in, o_uart_cts, o_uart_rxd};
  logic [11:0] idle = 12'hfc3;
  int          miscompares, samples_checked, cycles;
  // route table: flag, pin, mode code, peripheral bit (flag 1 input, 2 open drain, 4 with enable)
  logic [23:0] rt [$] = '{24'h00210d, 24'h01010d, 24'h01610d, 24'h00450d, 24'h00310e, 24'h01110e, 24'h01510e,
    24'h00550e, 24'h000510, 24'h009511, 24'h00a512, 24'h00b512, 24'h00250f, 24'h00750f, 24'h01750f, 24'h01950f,
    24'h005100, 24'h008100, 24'h017100, 24'h01101, 24'h06101, 24'h19101, 24'h12401, 24'h02404, 24'h0a404,
    24'h11404, 24'h17404, 24'h12107, 24'h14407, 24'h13108, 24'h16408, 24'h400402, 24'h401405, 24'h40a113,
    24'h20440b, 24'h20640b, 24'h20540c, 24'h20740c, 24'h20c409, 24'h20e109, 24'h20d40a, 24'h20f10a,
    24'h104100, 24'h10b100, 24'h118100, 24'h100101, 24'h107101, 24'h10d101, 24'h114101, 24'h113401,
    24'h101502, 24'h106502, 24'h108502, 24'h118502, 24'h103403, 24'h109403, 24'h110403, 24'h118403,
    24'h109104, 24'h100405, 24'h108405, 24'h10e405, 24'h119405, 24'h101406, 24'h10b406, 24'h10f406,
    24'h115406, 24'h10a107, 24'h10c408, 24'h10e108, 24'h10d409, 24'h10f109, 24'h10440a, 24'h10640a,
    24'h10540b, 24'h10740b};
  // trigger table: sense, both, polarity, start level, end level, expected pending
  logic [7:0]  ic [$] = '{8'h05, 8'h0b, 8'h13, 8'h1d, 8'h25, 8'h02, 8'h0c, 8'h28, 8'h26, 8'h2b};
  assign {i_swd_data_oe, i_swd_data_out, i_slow_clock_out, i_fast_crystal_clock_out, i_core_clock_out,
          i_mic_stream_clock_out, i_pulse_source_b, i_pulse_source_a, i_second_twowire_data_oe,
          i_second_twowire_clock_oe, i_first_twowire_data_oe, i_first_twowire_clock_oe, i_spi_select_three,
          i_spi_select_two, i_spi_select_one_oe, i_spi_select_one_out, i_spi_out, i_spi_clk_oe, i_spi_clk_out,
          i_uart_rts, i_uart_txd} = per;
  iom_mux  iom_mux_i (.*);
  iom_pads iom_pads_i (.i_clk(i_clk), .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe), .i_ext_val(ext_val),
                       .i_ext_en(ext_en), .o_pad_in(i_pad_in));
  always #20 i_clk = ~i_clk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // takes the values that stood up to this rising edge, then lets one cycle pass
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
    @(posedge i_clk);
  endtask
  task automatic clr;
    i_pin_irq_clear <= 26'h3ffffff;
    @(posedge i_clk);
    i_pin_irq_clear <= 26'h0;
  endtask
  // one pin in one mode: drive a peripheral out, or feed a pad in
  task automatic route(input logic [23:0] e);
    logic [77:0] m;
    m = 78'h0;
    m[3 * e[16:12] +: 3] = e[10:8];
    i_pin_mode <= m;
    if (e[20]) begin
      ext_en[e[16:12]] <= 1'b1;
      ext_val[e[16:12]] <= !idle[e[4:0]];
      cyc(6);
      check(pout[e[4:0]], !idle[e[4:0]]);
      ext_val[e[16:12]] <= idle[e[4:0]];
      cyc(6);
      check(pout[e[4:0]], idle[e[4:0]]);
      ext_en[e[16:12]] <= 1'b0;
    end else begin
      per <= (21'h1 << e[4:0]) | (e[22] ? 21'h1 << (e[4:0] + 5'h1) : 21'h0);
      cyc(4);
      check(o_pad_oe[e[16:12]], 1'b1);
      check(o_pad_out[e[16:12]], !e[21]);
      per <= 21'h0;
      cyc(4);
      check(e[22:21] != 2'h0 ? o_pad_oe[e[16:12]] : o_pad_out[e[16:12]], 1'b0);
    end
    i_pin_mode <= 78'h0;
    cyc(2);
  endtask
  // cuts a hung run short
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {i_clk, i_rst_n, i_pin_mode, i_pin_out_data, i_pin_oe, per, ext_val, ext_en} = '0;
    {i_irq_sense_select, i_irq_both_edge_select, i_irq_polarity_select} = '0;
    {i_pin_irq_enable_mask, i_pin_irq_clear} = '0;
    cyc(5);
    i_rst_n <= 1'b1;
    cyc(2);
    check(o_pad_oe, 26'h0);
    check(o_pin_irq_pending, 26'h0);
    check(26'(o_irq), 26'h0);
    for (int k = 0; k < 2; k++) begin
      i_pin_oe <= 26'h3ffffff;
      i_pin_out_data <= k ? 26'h1555555 : 26'h2aaaaaa;
      cyc(4);
      check(o_pad_oe, ~iom_pkg::INPUT_ONLY);
      check(o_pad_out & ~iom_pkg::INPUT_ONLY, i_pin_out_data & ~iom_pkg::INPUT_ONLY);
      check(o_pin_in_level & ~iom_pkg::INPUT_ONLY, i_pin_out_data & ~iom_pkg::INPUT_ONLY);
    end
    i_pin_oe <= 26'h0;
    cyc(3);
    check(o_pad_oe, 26'h0);
    foreach (rt[n]) route(rt[n]);
    i_pin_irq_enable_mask <= 26'h0000008;
    ext_en[3] <= 1'b1;
    foreach (ic[n]) begin
      {i_irq_sense_select[3], i_irq_both_edge_select[3], i_irq_polarity_select[3]} <= ic[n][5:3];
      ext_val[3] <= ic[n][2];
      cyc(5);
      clr();
      cyc(2);
      check(o_pin_irq_pending[3], 1'b0);
      ext_val[3] <= ic[n][1];
      cyc(5);
      check({o_irq, o_pin_irq_pending[3]}, {2{ic[n][0]}});
      clr();
      cyc(2);
      check(o_pin_irq_pending[3], ic[n][0] & ic[n][5]);
    end
    i_pin_irq_enable_mask <= 26'h0;
    cyc(2);
    check({o_irq, o_pin_irq_pending[3]}, 2'h1);
    {ext_en[12], ext_val[12]} <= 2'h3;
    i_irq_sense_select <= 26'h0001008;
    i_irq_polarity_select <= 26'h0001008;
    i_pin_irq_enable_mask <= 26'h0001000;
    cyc(5);
    check({o_irq, o_pin_irq_pending[12]}, 2'h3);
    i_pin_mode <= 78'h800;
    i_pin_irq_enable_mask <= 26'h0000008;
    cyc(2);
    clr();
    cyc(3);
    check({o_irq, o_pin_irq_pending[3]}, 2'h0);
    end_sim();
  end
endmodule
bind iom_mux iom_mux_assertions iom_mux_assertions_i (.*);
